// ---- logic/duc_dual_uart.v ----
// Two serial ports with control and status registers on the special function register port.
`timescale 1ns/1ps
`include "duc_consts.vh"
module duc_dual_uart #(
  parameter FIFO_DEPTH = `DUC_FIFO_DEPTH,
  parameter FIFO_AW = `DUC_FIFO_AW
) (
  input wire clock_i,
  input wire rst_b_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  output reg [7:0] sfr_rdata_o,
  input wire [15:0] primary_bit_period_i,
  input wire [15:0] secondary_bit_period_i,
  input wire baud_double_i,
  input wire primary_rxd_i,
  input wire secondary_rxd_i,
  output wire primary_txd_o,
  output wire secondary_txd_o,
  output wire primary_tx_ready_o
);

  // Nine-bit frame decode for one port's control byte.
  function nine_bit_of;
    input port;
    input [7:0] ctrl;
    begin
      if (port == 1'b0)
        nine_bit_of = ctrl[`DUC_MODE_HI_BIT];
      else
        nine_bit_of = ~ctrl[`DUC_MODE_HI_BIT];
    end
  endfunction

  // The secondary port is always usable; the primary port is usable unless it sits in its invalid mode.
  function mode_ok_of;
    input port;
    input [7:0] ctrl;
    begin
      if (port == 1'b0)
        mode_ok_of = ctrl[`DUC_MODE_HI_BIT] | ctrl[`DUC_MODE_LO_BIT];
      else
        mode_ok_of = 1'b1;
    end
  endfunction

  wire [15:0] ctrl_bus;
  wire [15:0] rxbuf_bus;
  wire [1:0] txd_bus;
  wire [1:0] src_valid;
  wire [15:0] src_data;
  wire [1:0] take;
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire wr_buf0;
  wire wr_buf1;
  reg hold_valid;
  reg [7:0] hold_data;

  assign wr_buf0 = sfr_wr_i && (sfr_addr_i == `DUC_BUF0_ADDR);
  assign wr_buf1 = sfr_wr_i && (sfr_addr_i == `DUC_BUF1_ADDR);
  assign primary_txd_o = txd_bus[0];
  assign secondary_txd_o = txd_bus[1];

  // Primary transmit bytes queue here; a write while full is dropped.
  duc_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_tx_fifo (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(wr_buf0),
    .in_data_i(sfr_wdata_i),
    .in_ready_o(primary_tx_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(take[0])
  );

  // Secondary port keeps one byte waiting while the shifter is busy.
  always @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hold_valid <= 1'b0;
      hold_data <= `DUC_BUF_RESET;
    end
    else if (wr_buf1 && (!hold_valid || take[1]))
    begin
      hold_valid <= 1'b1;
      hold_data <= sfr_wdata_i;
    end
    else if (take[1])
      hold_valid <= 1'b0;
  end

  assign src_valid = {hold_valid, fifo_valid};
  assign src_data = {hold_data, fifo_data};

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : g_port
      reg [7:0] ctrl;
      reg [7:0] next_ctrl;
      reg [7:0] rx_buf;
      reg [15:0] period;
      wire nine;
      wire mode_ok;
      wire wr_ctrl;
      wire mpe;
      wire ren;
      // Transmit side.
      reg tx_busy;
      reg [10:0] tx_sh;
      reg [3:0] tx_left;
      reg [15:0] tx_cnt;
      reg txd;
      reg tx_fin;
      // Receive side.
      reg rx_meta;
      reg rx_sync;
      reg rx_prev;
      reg rx_busy;
      reg [15:0] rx_cnt;
      reg [3:0] rx_idx;
      reg [9:0] rx_sh;
      reg rx_fin;
      reg rx_acc;
      reg rx_b8;
      reg [7:0] rx_byte;
      reg [9:0] full;

      assign nine = nine_bit_of(p != 0, ctrl);
      assign mode_ok = mode_ok_of(p != 0, ctrl);
      assign mpe = ctrl[`DUC_MPE_BIT];
      assign ren = ctrl[`DUC_REN_BIT];
      assign wr_ctrl = sfr_wr_i &&
        (sfr_addr_i == ((p == 0) ? `DUC_CTRL0_ADDR : `DUC_CTRL1_ADDR));
      assign take[p] = ~tx_busy & src_valid[p] & mode_ok;
      assign txd_bus[p] = txd;
      assign ctrl_bus[p*8 +: 8] = ctrl;
      assign rxbuf_bus[p*8 +: 8] = rx_buf;

      // Clocks per bit: fixed in primary mode 2, else the supplied period.
      always @*
      begin
        if (p == 0 && ctrl[7:6] == 2'b10)
          period = baud_double_i ? `DUC_FIXED_DIV_FAST : `DUC_FIXED_DIV_SLOW;
        else if (p == 0)
          period = primary_bit_period_i;
        else
          period = secondary_bit_period_i;
        if (period < `DUC_MIN_PERIOD)
          period = `DUC_MIN_PERIOD;
      end

      // Frame shifter, least significant bit first.
      always @(posedge clock_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          tx_busy <= 1'b0;
          tx_sh <= 11'h7FF;
          tx_left <= 4'h0;
          tx_cnt <= 16'h0000;
          txd <= 1'b1;
          tx_fin <= 1'b0;
        end
        else
        begin
          tx_fin <= 1'b0;
          if (take[p])
          begin
            tx_busy <= 1'b1;
            if (nine)
            begin
              tx_sh <= {1'b1, ctrl[`DUC_TB8_BIT], src_data[p*8 +: 8], 1'b0};
              tx_left <= `DUC_FRAME9_BITS;
            end
            else
            begin
              tx_sh <= {2'b11, src_data[p*8 +: 8], 1'b0};
              tx_left <= `DUC_FRAME8_BITS;
            end
            txd <= 1'b0;
            tx_cnt <= period - 16'h0001;
          end
          else if (tx_busy)
          begin
            if (tx_cnt != 16'h0000)
              tx_cnt <= tx_cnt - 16'h0001;
            else if (tx_left == 4'h1)
            begin
              tx_busy <= 1'b0;
              txd <= 1'b1;
              tx_fin <= 1'b1;
            end
            else
            begin
              tx_sh <= {1'b1, tx_sh[10:1]};
              txd <= tx_sh[1];
              tx_left <= tx_left - 4'h1;
              tx_cnt <= period - 16'h0001;
            end
          end
        end
      end

      // Completed frame as held in the shifter, and frame qualification.
      always @*
      begin
        full = rx_sh;
        if (nine)
        begin
          rx_byte = full[7:0];
          rx_b8 = full[8];
          rx_acc = ~mpe | full[8];
        end
        else
        begin
          rx_byte = full[8:1];
          rx_b8 = full[9];
          rx_acc = ~mpe | full[9];
        end
      end

      // Receiver: start edge, mid-bit sampling, stop bit.
      always @(posedge clock_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          rx_meta <= 1'b1;
          rx_sync <= 1'b1;
          rx_prev <= 1'b1;
          rx_busy <= 1'b0;
          rx_cnt <= 16'h0000;
          rx_idx <= 4'h0;
          rx_sh <= 10'h000;
          rx_fin <= 1'b0;
        end
        else
        begin
          rx_meta <= (p == 0) ? primary_rxd_i : secondary_rxd_i;
          rx_sync <= rx_meta;
          rx_prev <= rx_sync;
          rx_fin <= 1'b0;
          if (!ren || !mode_ok)
            rx_busy <= 1'b0;
          else if (!rx_busy)
          begin
            if (rx_prev && !rx_sync)
            begin
              rx_busy <= 1'b1;
              rx_cnt <= {1'b0, period[15:1]};
              rx_idx <= 4'h0;
            end
          end
          else if (rx_cnt != 16'h0000)
            rx_cnt <= rx_cnt - 16'h0001;
          else
          begin
            rx_cnt <= period - 16'h0001;
            if (rx_idx == 4'h0 && rx_sync)
              rx_busy <= 1'b0;
            else if (rx_idx == (nine ? `DUC_FRAME9_BITS : `DUC_FRAME8_BITS) - 4'h1)
            begin
              rx_busy <= 1'b0;
              rx_fin <= 1'b1;
              rx_sh <= {rx_sync, rx_sh[9:1]};
            end
            else
            begin
              if (rx_idx != 4'h0)
                rx_sh <= {rx_sync, rx_sh[9:1]};
              rx_idx <= rx_idx + 4'h1;
            end
          end
        end
      end

      // Control byte: software writes, hardware sets; a set wins over a clear.
      always @*
      begin
        next_ctrl = ctrl;
        if (wr_ctrl)
        begin
          next_ctrl = sfr_wdata_i;
          if (p == 1)
            next_ctrl[`DUC_MODE_LO_BIT] = 1'b0;
        end
        if (tx_fin)
          next_ctrl[`DUC_TI_BIT] = 1'b1;
        if (rx_fin && rx_acc)
        begin
          next_ctrl[`DUC_RI_BIT] = 1'b1;
          next_ctrl[`DUC_RB8_BIT] = rx_b8;
        end
      end

      always @(posedge clock_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          ctrl <= `DUC_CTRL_RESET;
          rx_buf <= `DUC_BUF_RESET;
        end
        else
        begin
          ctrl <= next_ctrl;
          if (rx_fin && rx_acc)
            rx_buf <= rx_byte;
        end
      end
    end
  endgenerate

  // Read data is registered on the read strobe; unmapped addresses give zero.
  always @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      sfr_rdata_o <= `DUC_RDATA_RESET;
    else if (sfr_rd_i)
    begin
      case (sfr_addr_i)
        `DUC_CTRL0_ADDR: sfr_rdata_o <= ctrl_bus[7:0];
        `DUC_CTRL1_ADDR: sfr_rdata_o <= ctrl_bus[15:8];
        `DUC_BUF0_ADDR: sfr_rdata_o <= rxbuf_bus[7:0];
        `DUC_BUF1_ADDR: sfr_rdata_o <= rxbuf_bus[15:8];
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

// ---- logic/duc_consts.vh ----
// Register addresses, field positions and timing constants of the dual serial control block.
`ifndef DUC_CONSTS_VH
`define DUC_CONSTS_VH

// Special function register addresses.
`define DUC_BUF0_ADDR 8'h99
`define DUC_BUF1_ADDR 8'h9C
`define DUC_CTRL0_ADDR 8'h9A
`define DUC_CTRL1_ADDR 8'h9D

// Field positions inside each port control register.
`define DUC_MODE_HI_BIT 7
`define DUC_MODE_LO_BIT 6
`define DUC_MPE_BIT 5
`define DUC_REN_BIT 4
`define DUC_TB8_BIT 3
`define DUC_RB8_BIT 2
`define DUC_TI_BIT 1
`define DUC_RI_BIT 0

// Reset values.
`define DUC_CTRL_RESET 8'h00
`define DUC_BUF_RESET 8'h00
`define DUC_RDATA_RESET 8'h00

// Fixed-rate mode clocks per bit with and without baud doubling.
`define DUC_FIXED_DIV_FAST 16'h0020
`define DUC_FIXED_DIV_SLOW 16'h0040

// Serial frame lengths in bit times, start and stop included.
`define DUC_FRAME8_BITS 4'h0A
`define DUC_FRAME9_BITS 4'h0B

// Shortest usable bit period in clocks.
`define DUC_MIN_PERIOD 16'h0002

// Transmit FIFO shape.
`define DUC_FIFO_DEPTH 16
`define DUC_FIFO_AW 4

`endif

// ---- logic/duc_fifo.v ----
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module duc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock_i,
  input wire rst_b_i,
  input wire in_valid_i,
  input wire [WIDTH-1:0] in_data_i,
  output reg in_ready_o,
  output wire out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input wire out_ready_i
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  reg [AW:0] next_count;
  wire push;
  wire pop;

  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @*
  begin
    next_count = count;
    if (push & ~pop)
      next_count = count + 1'b1;
    else if (pop & ~push)
      next_count = count - 1'b1;
  end

  always @(posedge clock_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  // Ready is a flop so the full flag reaches the writer without a combinational path.
  always @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready_o <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      count <= next_count;
      in_ready_o <= (next_count != DEPTH[AW:0]);
    end
  end

endmodule

// ---- tb/duc_dual_uart_chk.sv ----
// Checker of register reads and serial line timing at the dual serial ports.
`timescale 1ns/1ps
`include "duc_consts.vh"
module duc_dual_uart_chk #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire clock_i,
  input wire rst_b_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_rdata_o,
  input wire [15:0] primary_bit_period_i,
  input wire [15:0] secondary_bit_period_i,
  input wire baud_double_i,
  input wire primary_rxd_i,
  input wire secondary_rxd_i,
  input wire primary_txd_o,
  input wire secondary_txd_o,
  input wire primary_tx_ready_o
);
  reg [1:0] mode0;
  reg rd0_d;
  reg [1:0] seen;
  reg [9:0] lo_cnt;
  wire rd0 = sfr_rd_i && sfr_addr_i == `DUC_CTRL0_ADDR;
  wire wr0 = sfr_wr_i && sfr_addr_i == `DUC_CTRL0_ADDR;
  // Seen holds the flags of the last primary control read, forgotten on any primary control write.
  always @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mode0 <= 2'h0;
      rd0_d <= 1'b0;
      seen <= 2'h0;
      lo_cnt <= 10'h000;
    end
    else
    begin
      rd0_d <= rd0;
      if (wr0)
      begin
        mode0 <= sfr_wdata_i[7:6];
        seen <= 2'h0;
      end
      else if (rd0_d)
        seen <= sfr_rdata_o[1:0];
      lo_cnt <= primary_txd_o ? 10'h000 : lo_cnt + 10'h001;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_lines_idle_reset: assert property ($rose(rst_b_i) |-> primary_txd_o &&
    secondary_txd_o && primary_tx_ready_o) else $error("lines not idle after reset");
  a_unmapped_read_zero: assert property (sfr_rd_i && !(sfr_addr_i inside
    {`DUC_BUF0_ADDR, `DUC_BUF1_ADDR, `DUC_CTRL0_ADDR, `DUC_CTRL1_ADDR}) |=>
    sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data changed without a read");
  a_sec_bit_six: assert property (sfr_rd_i && sfr_addr_i == `DUC_CTRL1_ADDR
    |=> !sfr_rdata_o[6]) else $error("secondary bit six not zero");
  a_ctrl_write_back: assert property (wr0 ##2 rd0 |=>
    sfr_rdata_o[7:3] == $past(sfr_wdata_i[7:3], 3)) else $error("control readback wrong");
  a_tx_flag_sticky: assert property (rd0 && seen[1] |=> sfr_rdata_o[1])
    else $error("transmit done flag lost");
  a_rx_flag_sticky: assert property (rd0 && seen[0] |=> sfr_rdata_o[0])
    else $error("receive done flag lost");
  a_mode2_bit_rate: assert property ($rose(primary_txd_o) && mode0 == 2'h2 |->
    lo_cnt % (baud_double_i ? 32 : 64) == 0) else $error("fixed rate bit length wrong");
  a_start_bit_hold: assert property ($fell(secondary_txd_o) |=> !secondary_txd_o)
    else $error("start bit too short");
  c_mode2_frame: cover property ($rose(primary_txd_o) && mode0 == 2'h2);
  c_tx_sticky: cover property (rd0 && seen[1]);
  c_rx_sticky: cover property (rd0 && seen[0]);
endmodule
bind duc_dual_uart duc_dual_uart_chk #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW))
  duc_dual_uart_chk_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
  .sfr_rdata_o(sfr_rdata_o), .primary_bit_period_i(primary_bit_period_i),
  .secondary_bit_period_i(secondary_bit_period_i), .baud_double_i(baud_double_i),
  .primary_rxd_i(primary_rxd_i), .secondary_rxd_i(secondary_rxd_i),
  .primary_txd_o(primary_txd_o), .secondary_txd_o(secondary_txd_o),
  .primary_tx_ready_o(primary_tx_ready_o));

// ---- tb/duc_serial_host.sv ----
// Serial host model that sends frames to and captures frames from both ports.
`timescale 1ns/1ps
module duc_serial_host (
  input wire clock_i,
  input wire [1:0] txd_i,
  output reg [1:0] rxd_o
);
  initial rxd_o = 2'h3;
  task send(input integer p, input [8:0] d, input integer n, input integer per);
    integer b;
    begin
      for (b = -1; b <= n; b = b + 1)
      begin
        rxd_o[p] = (b < 0) ? 1'b0 : (b == n) ? 1'b1 : d[b];
        repeat (per) @(posedge clock_i);
        #1;
      end
      // Two idle clocks let the receiver post its flags before the caller reads.
      repeat (2) @(posedge clock_i);
      #1;
    end
  endtask
  // Waits a bounded time for a start bit, then samples each bit at its middle.
  task get(input integer p, input integer n, input integer per, output [9:0] d,
    output ok);
    integer b;
    integer w;
    begin
      d = 10'h000;
      ok = 1'b0;
      w = 0;
      while (txd_i[p] !== 1'b0 && w < 4000)
      begin
        @(posedge clock_i);
        w = w + 1;
      end
      if (w < 4000)
      begin
        ok = 1'b1;
        repeat (per / 2) @(posedge clock_i);
        for (b = 0; b <= n; b = b + 1)
        begin
          repeat (per) @(posedge clock_i);
          d[b] = txd_i[p];
        end
        // Waits past the stop bit so the transmit done flag is posted first.
        repeat (per / 2 + 1) @(posedge clock_i);
      end
      #1;
    end
  endtask
endmodule

// ---- tb/duc_dual_uart_tb_top.sv ----
// Testbench of the dual serial ports driven through the register port.
`timescale 1ns/1ps
`include "duc_consts.vh"
module duc_dual_uart_tb_top;
  localparam [7:0] c0 = `DUC_CTRL0_ADDR;
  localparam [7:0] c1 = `DUC_CTRL1_ADDR;
  localparam [7:0] b0 = `DUC_BUF0_ADDR;
  localparam [7:0] b1 = `DUC_BUF1_ADDR;
  reg clock_i;
  reg rst_b;
  reg [7:0] addr;
  reg [7:0] wdata;
  reg wr_s;
  reg rd_s;
  reg bdbl;
  wire [7:0] rdata;
  wire [1:0] rxd;
  wire [1:0] txd;
  wire rdy;
  reg [9:0] got;
  reg ok;
  integer errors;
  integer check_count;
  integer k;
  integer n;
  duc_dual_uart duc_dual_uart_i (.clock_i(clock_i), .rst_b_i(rst_b), .sfr_addr_i(addr),
    .sfr_wdata_i(wdata), .sfr_wr_i(wr_s), .sfr_rd_i(rd_s), .sfr_rdata_o(rdata),
    .primary_bit_period_i(16'h0008), .secondary_bit_period_i(16'h0008),
    .baud_double_i(bdbl), .primary_rxd_i(rxd[0]), .secondary_rxd_i(rxd[1]),
    .primary_txd_o(txd[0]), .secondary_txd_o(txd[1]), .primary_tx_ready_o(rdy));
  duc_serial_host duc_serial_host_i (.clock_i(clock_i), .txd_i(txd), .rxd_o(rxd));
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task chk(input [9:0] g, input [9:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      @(posedge clock_i);
      #1;
      wr_s = 1'b0;
      @(posedge clock_i);
      #1;
    end
  endtask
  task rc(input [7:0] a, input [7:0] e);
    begin
      addr = a;
      rd_s = 1'b1;
      @(posedge clock_i);
      #1;
      rd_s = 1'b0;
      @(posedge clock_i);
      #1;
      chk({2'h0, rdata}, {2'h0, e});
    end
  endtask
  task gx(input integer p, input integer nb, input integer per, input [9:0] e);
    begin
      duc_serial_host_i.get(p, nb, per, got, ok);
      chk({9'h000, ok}, 10'h001);
      chk(got, e);
    end
  endtask
  task te(input integer t);
    $display("test %0d finished", t);
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial
  begin
    errors = 0;
    check_count = 0;
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    bdbl = 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
    rst_b = 1'b1;
    rc(c0, 8'h00);
    rc(c1, 8'h00);
    rc(8'h50, 8'h00);
    te(1);
    wr(c0, 8'h50);
    wr(b0, 8'hA5);
    gx(0, 8, 8, 10'h1A5);
    rc(c0, 8'h52);
    rc(c0, 8'h52);
    wr(c0, 8'h50);
    rc(c0, 8'h50);
    te(2);
    for (k = 0; k < 2; k = k + 1)
    begin
      bdbl = k[0];
      wr(c0, 8'h88);
      wr(b0, 8'hFF);
      gx(0, 9, k ? 32 : 64, 10'h3FF);
    end
    wr(c0, 8'hC0);
    wr(b0, 8'h3C);
    gx(0, 9, 8, 10'h23C);
    te(3);
    wr(c0, 8'h00);
    wr(b0, 8'h11);
    duc_serial_host_i.get(0, 8, 8, got, ok);
    chk({9'h000, ok}, 10'h000);
    wr(c0, 8'h40);
    gx(0, 8, 8, 10'h111);
    te(4);
    wr(c0, 8'hD0);
    duc_serial_host_i.send(0, 9'h15A, 9, 8);
    rc(b0, 8'h5A);
    rc(c0, 8'hD5);
    wr(c0, 8'hC0);
    duc_serial_host_i.send(0, 9'h1C3, 9, 8);
    rc(c0, 8'hC0);
    rc(b0, 8'h5A);
    wr(c0, 8'hF0);
    duc_serial_host_i.send(0, 9'h077, 9, 8);
    rc(c0, 8'hF0);
    rc(b0, 8'h5A);
    duc_serial_host_i.send(0, 9'h178, 9, 8);
    rc(b0, 8'h78);
    rc(c0, 8'hF5);
    rc(c0, 8'hF5);
    te(5);
    wr(c1, 8'h90);
    duc_serial_host_i.send(1, 9'h033, 8, 8);
    rc(b1, 8'h33);
    rc(c1, 8'h95);
    wr(c1, 8'h10);
    rc(c1, 8'h10);
    wr(c1, 8'h08);
    wr(b1, 8'hC3);
    gx(1, 9, 8, 10'h3C3);
    rc(c1, 8'h0A);
    wr(c1, 8'h80);
    wr(b1, 8'h5E);
    gx(1, 8, 8, 10'h15E);
    wr(c1, 8'h40);
    rc(c1, 8'h00);
    te(6);
    wr(c0, 8'h00);
    n = 0;
    while (rdy === 1'b1 && n < 40)
    begin
      wr(b0, n[7:0]);
      n = n + 1;
    end
    chk({9'h000, n >= 16}, 10'h001);
    chk({9'h000, rdy}, 10'h000);
    wr(c0, 8'h40);
    for (k = 0; k < n; k = k + 1)
      gx(0, 8, 8, {2'h1, k[7:0]});
    chk({9'h000, rdy}, 10'h001);
    te(7);
    print_verdict;
  end
endmodule
